// File: hw/mmt_master.sv
// Master end: APB-controlled issuer with setup, hold, pending and burst limits
//
// The register offsets and the APB register port were left to the implementer.
`timescale 1ns/1ns
`include "mmt_defs.svh"
module mmt_master #(
  parameter int                 STROBE_SETUP_INTERVAL  = `MMT_DEF_SETUP,
  parameter int                 STROBE_HOLD_INTERVAL   = `MMT_DEF_HOLD,
  parameter mmt_pkg::mmt_unit_e DELAY_UNIT_SELECT      = mmt_pkg::MMT_UNIT_CYCLES,
  parameter int                 OUTSTANDING_READ_LIMIT = `MMT_DEF_PENDING,
  parameter bit                 ALIGNED_BURST_ONLY     = 1'b0,
  parameter int                 BURST_LENGTH_LIMIT     = `MMT_DEF_BURST,
  parameter bit                 USE_READDATAVALID      = 1'b0
) (
  // Clock and reset
  input  wire logic                   clk_i,
  input  wire logic                   reset_i,
  // APB slave
  input  wire logic                   psel_i,
  input  wire logic                   penable_i,
  input  wire logic                   pwrite_i,
  input  wire logic [11:0]            paddr_i,
  input  wire logic [31:0]            pwdata_i,
  output logic [31:0]                 prdata_o,
  output logic                        pready_o,
  output logic                        pslverr_o,
  // Link
  mmt_link_if.master_mp               link
);
  import mmt_pkg::*;

  function automatic int to_cycles(input int v);
    if (DELAY_UNIT_SELECT == MMT_UNIT_NS)
      return (v + `MMT_CLK_PERIOD_NS - 1) / `MMT_CLK_PERIOD_NS;
    return v;
  endfunction

  localparam int SETUP_CYC = to_cycles(STROBE_SETUP_INTERVAL);
  localparam int HOLD_CYC  = to_cycles(STROBE_HOLD_INTERVAL);

  initial begin
    if (OUTSTANDING_READ_LIMIT < 1 || OUTSTANDING_READ_LIMIT > `MMT_MAX_PENDING)
      $error("pending read limit out of range");
    if (BURST_LENGTH_LIMIT < 1 || BURST_LENGTH_LIMIT > `MMT_MAX_BURST) $error("burst range");
    if (STROBE_SETUP_INTERVAL > `MMT_MAX_WAIT || STROBE_HOLD_INTERVAL > `MMT_MAX_WAIT)
      $error("setup or hold out of range");
  end

  // ==========================================================
  // Registers
  logic                     wr_q;
  logic [`MMT_BE_W-1:0]     be_q;
  logic [`MMT_BCNT_W-1:0]   bcnt_q;
  logic [`MMT_ADDR_W-1:0]   addr_q;
  logic [`MMT_DATA_W-1:0]   wdata_q;
  logic [`MMT_DATA_W-1:0]   rdata_q;
  logic                     rdone_q;
  logic                     align_err_q;
  logic                     burst_err_q;
  logic [6:0]               pend_q;
  mmt_mst_state_e           state_q;
  logic [10:0]              tmr_q;
  logic [`MMT_BCNT_W-1:0]   left_q;
  logic                     wr_acc;
  logic                     go;
  logic                     rd_ret;
  logic                     bad_align;
  logic                     bad_burst;

  assign wr_acc = psel_i && penable_i && pwrite_i && pready_o;
  assign go     = wr_acc && paddr_i == `MMT_REG_CTRL && pwdata_i[`MMT_CTRL_GO];
  assign bad_burst = pwdata_i[`MMT_CTRL_BCNT_LO +: `MMT_BCNT_W] == '0 ||
                     32'(pwdata_i[`MMT_CTRL_BCNT_LO +: `MMT_BCNT_W]) > BURST_LENGTH_LIMIT;
  assign bad_align = ALIGNED_BURST_ONLY &&
                     ((32'(addr_q) >> 2) % 32'(pwdata_i[`MMT_CTRL_BCNT_LO +: `MMT_BCNT_W])) != 0;

  // APB: one wait cycle, reply in access phase
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o  <= '0;
    end else begin
      pready_o  <= psel_i && penable_i && !pready_o;
      pslverr_o <= 1'b0;
      prdata_o  <= '0;
      if (psel_i && penable_i && !pready_o && !pwrite_i) begin
        unique case (paddr_i)
          `MMT_REG_ADDR:   prdata_o <= 32'(addr_q);
          `MMT_REG_WDATA:  prdata_o <= wdata_q;
          `MMT_REG_RDATA:  prdata_o <= rdata_q;
          `MMT_REG_STATUS: prdata_o <= {16'h0000, 1'b0, pend_q, 4'h0, burst_err_q,
                                        align_err_q, rdone_q, state_q != MMT_IDLE};
          `MMT_REG_CFG:    prdata_o <= 32'(BURST_LENGTH_LIMIT);
          `MMT_REG_CTRL:   prdata_o <= {16'h0000, 1'b0, bcnt_q, be_q, 2'b00, wr_q, 1'b0};
          default:         pslverr_o <= 1'b1;
        endcase
      end else if (psel_i && penable_i && !pready_o && !(paddr_i == `MMT_REG_CTRL ||
                   paddr_i == `MMT_REG_ADDR || paddr_i == `MMT_REG_WDATA ||
                   paddr_i == `MMT_REG_STATUS)) begin
        pslverr_o <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      addr_q  <= '0;
      wdata_q <= '0;
    end else if (wr_acc && state_q == MMT_IDLE) begin
      if (paddr_i == `MMT_REG_ADDR) addr_q <= pwdata_i[`MMT_ADDR_W-1:0];
      if (paddr_i == `MMT_REG_WDATA) wdata_q <= pwdata_i;
    end
  end

  // Error and done flags: set wins over clear
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      align_err_q <= 1'b0;
      burst_err_q <= 1'b0;
      rdone_q     <= 1'b0;
      rdata_q     <= '0;
    end else begin
      if (wr_acc && paddr_i == `MMT_REG_STATUS) begin
        if (pwdata_i[`MMT_STAT_ALIGN_ERR]) align_err_q <= 1'b0;
        if (pwdata_i[`MMT_STAT_BURST_ERR]) burst_err_q <= 1'b0;
        if (pwdata_i[`MMT_STAT_RDONE]) rdone_q <= 1'b0;
      end
      if (go && state_q == MMT_IDLE && bad_burst) burst_err_q <= 1'b1;
      if (go && state_q == MMT_IDLE && !bad_burst && bad_align) align_err_q <= 1'b1;
      if (rd_ret) begin
        rdone_q <= 1'b1;
        rdata_q <= link.readdata;
      end
    end
  end

  // ==========================================================
  // Link sequencer
  logic strobe_done;
  assign strobe_done = state_q == MMT_STROBE && !link.waitrequest;
  // Read data arrives by valid pulse, or with the accepting edge
  assign rd_ret = USE_READDATAVALID ? link.readdatavalid : (strobe_done && !wr_q);

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      pend_q <= '0;
    end else if (USE_READDATAVALID) begin
      pend_q <= pend_q + 7'(strobe_done && !wr_q) - 7'(link.readdatavalid);
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      state_q <= MMT_IDLE;
      tmr_q   <= '0;
      wr_q    <= 1'b0;
      be_q    <= '0;
      bcnt_q  <= '0;
      left_q  <= '0;
    end else begin
      unique case (state_q)
        MMT_IDLE: begin
          if (go && !bad_burst && !bad_align) begin
            wr_q    <= pwdata_i[`MMT_CTRL_WRITE];
            be_q    <= pwdata_i[`MMT_CTRL_BE_LO +: `MMT_BE_W];
            bcnt_q  <= pwdata_i[`MMT_CTRL_BCNT_LO +: `MMT_BCNT_W];
            left_q  <= pwdata_i[`MMT_CTRL_BCNT_LO +: `MMT_BCNT_W];
            tmr_q   <= 11'(SETUP_CYC);
            state_q <= MMT_SETUP;
          end
        end
        MMT_SETUP: begin
          if (tmr_q != '0) tmr_q <= tmr_q - 11'h001;
          else if (wr_q || pend_q < 7'(OUTSTANDING_READ_LIMIT)) state_q <= MMT_STROBE;
        end
        MMT_STROBE: begin
          if (strobe_done) begin
            left_q <= left_q - `MMT_BCNT_W'(1);
            if (left_q != `MMT_BCNT_W'(1)) begin
              // Further burst beats, subject to pending limit
              if (!wr_q && pend_q + 7'h01 >= 7'(OUTSTANDING_READ_LIMIT) && USE_READDATAVALID)
                state_q <= MMT_SETUP;
            end else if (wr_q) begin
              tmr_q   <= 11'(HOLD_CYC);
              state_q <= MMT_HOLD;
            end else begin
              state_q <= MMT_IDLE;
            end
          end
        end
        MMT_HOLD: begin
          if (tmr_q != '0) tmr_q <= tmr_q - 11'h001;
          else state_q <= MMT_IDLE;
        end
      endcase
    end
  end

  // Link drives: chipselect spans setup, strobe and hold
  assign link.chipselect = state_q != MMT_IDLE;
  assign link.read       = state_q == MMT_STROBE && !wr_q;
  assign link.write      = state_q == MMT_STROBE && wr_q;
  assign link.address    = addr_q;
  assign link.byteenable = be_q;
  assign link.writedata  = wdata_q;
  assign link.burstcount = bcnt_q;
  assign link.beginbursttransfer = state_q == MMT_STROBE && left_q == bcnt_q && !link.waitrequest;
endmodule

// File: hw/mmt_defs.svh
// Constants for the memory-mapped slave timing link
`ifndef MMT_DEFS_SVH
`define MMT_DEFS_SVH
`define MMT_ADDR_W           16
`define MMT_DATA_W           32
`define MMT_BE_W             4
`define MMT_BCNT_W           7
`define MMT_MAX_READ_DELAY   63
`define MMT_MAX_WAIT         1000
`define MMT_MAX_PENDING      64
`define MMT_MAX_BURST        64
`define MMT_DEF_READ_DELAY   0
`define MMT_DEF_WRITE_WAIT   0
`define MMT_DEF_READ_WAIT    1
`define MMT_DEF_HOLD         0
`define MMT_DEF_SETUP        0
`define MMT_DEF_PENDING      1
`define MMT_DEF_BURST        1
`define MMT_CLK_PERIOD_NS    10
// APB register offsets of the master end
`define MMT_REG_CTRL         12'h000
`define MMT_REG_ADDR         12'h004
`define MMT_REG_WDATA        12'h008
`define MMT_REG_STATUS       12'h00C
`define MMT_REG_RDATA        12'h010
`define MMT_REG_CFG          12'h014
// Control word fields
`define MMT_CTRL_GO          0
`define MMT_CTRL_WRITE       1
`define MMT_CTRL_BE_LO       4
`define MMT_CTRL_BCNT_LO     8
// Status word fields
`define MMT_STAT_BUSY        0
`define MMT_STAT_RDONE       1
`define MMT_STAT_ALIGN_ERR   2
`define MMT_STAT_BURST_ERR   3
`define MMT_STAT_PEND_LO     8
`endif

// File: hw/mmt_pkg.sv
// Types for the memory-mapped slave timing link
package mmt_pkg;
  typedef enum logic {MMT_UNIT_CYCLES, MMT_UNIT_NS} mmt_unit_e;
  typedef enum logic [1:0] {MMT_IDLE, MMT_SETUP, MMT_STROBE, MMT_HOLD} mmt_mst_state_e;
endpackage

// File: hw/mmt_link_if.sv
// Link between the memory-mapped master end and the slave end
`timescale 1ns/1ns
`include "mmt_defs.svh"
interface mmt_link_if;
  logic                     chipselect;
  logic                     read;
  logic                     write;
  logic [`MMT_ADDR_W-1:0]   address;
  logic [`MMT_BE_W-1:0]     byteenable;
  logic [`MMT_DATA_W-1:0]   writedata;
  logic [`MMT_BCNT_W-1:0]   burstcount;
  logic                     beginbursttransfer;
  logic [`MMT_DATA_W-1:0]   readdata;
  logic                     readdatavalid;
  logic                     waitrequest;
  modport slave_mp (
    input  chipselect, read, write, address, byteenable, writedata, burstcount,
           beginbursttransfer,
    output readdata, readdatavalid, waitrequest
  );
  modport master_mp (
    output chipselect, read, write, address, byteenable, writedata, burstcount,
           beginbursttransfer,
    input  readdata, readdatavalid, waitrequest
  );
endinterface

// File: hw/mmt_slave.sv
// Slave end: fixed wait states, fixed read latency with or without valid pulse, bursts, bridging
`timescale 1ns/1ns
`include "mmt_defs.svh"
module mmt_slave #(
  parameter int                 FIXED_READ_DELAY      = `MMT_DEF_READ_DELAY,
  parameter int                 WRITE_WAIT_COUNT      = `MMT_DEF_WRITE_WAIT,
  parameter int                 READ_WAIT_COUNT       = `MMT_DEF_READ_WAIT,
  parameter mmt_pkg::mmt_unit_e DELAY_UNIT_SELECT     = mmt_pkg::MMT_UNIT_CYCLES,
  parameter bit                 USE_READDATAVALID     = 1'b0,
  parameter bit                 WRAPPING_BURST_ENABLE = 1'b0,
  parameter int                 BURST_LENGTH_LIMIT    = `MMT_DEF_BURST,
  parameter int                 MEM_WORDS             = 64
) (
  // Clock and reset
  input  wire logic                   clk_i,
  input  wire logic                   reset_i,
  // Link
  mmt_link_if.slave_mp                link,
  // Paired master bridge side
  output logic                        bridge_req_o,
  output logic                        bridge_write_o,
  output logic [`MMT_ADDR_W-1:0]      bridge_addr_o,
  output logic [`MMT_BE_W-1:0]        bridge_be_o,
  output logic [`MMT_DATA_W-1:0]      bridge_wdata_o
);
  import mmt_pkg::*;

  // Wait counts converted to cycles
  function automatic int to_cycles(input int v);
    if (DELAY_UNIT_SELECT == MMT_UNIT_NS)
      return (v + `MMT_CLK_PERIOD_NS - 1) / `MMT_CLK_PERIOD_NS;
    return v;
  endfunction

  localparam int WR_WAIT = to_cycles(WRITE_WAIT_COUNT);
  localparam int RD_WAIT = to_cycles(READ_WAIT_COUNT);
  localparam int RD_LAT  = USE_READDATAVALID ? (FIXED_READ_DELAY < 1 ? 1 : FIXED_READ_DELAY)
                                             : FIXED_READ_DELAY;
  localparam int IDX_W   = $clog2(MEM_WORDS);
  localparam int PIPE_N  = RD_LAT < 1 ? 1 : RD_LAT;

  initial begin
    if (FIXED_READ_DELAY < 0 || FIXED_READ_DELAY > `MMT_MAX_READ_DELAY)
      $error("read delay out of range");
    if (WRITE_WAIT_COUNT < 0 || WRITE_WAIT_COUNT > `MMT_MAX_WAIT) $error("write wait range");
    if (READ_WAIT_COUNT < 0 || READ_WAIT_COUNT > `MMT_MAX_WAIT) $error("read wait range");
    if (BURST_LENGTH_LIMIT < 1 || BURST_LENGTH_LIMIT > `MMT_MAX_BURST) $error("burst range");
    if (MEM_WORDS < 2 || (1 << IDX_W) != MEM_WORDS) $error("memory size not power of two");
  end

  // ==========================================================
  // Wait-state counter and burst tracking
  logic [10:0]            wait_q;
  logic                   active_q;
  logic [`MMT_BCNT_W-1:0] beats_q;
  logic [`MMT_ADDR_W-1:0] burst_addr_q;
  logic [`MMT_ADDR_W-1:0] base_addr_q;
  logic                   req;
  logic                   accept;
  logic [`MMT_ADDR_W-1:0] cur_addr;
  logic [10:0]            first_wait;

  assign req = link.chipselect && (link.read || link.write);
  // Address of current beat: first beat from the bus, later from the counter
  assign cur_addr = (beats_q == '0) ? link.address : burst_addr_q;
  // Wait count of the request now on the bus
  assign first_wait = link.write ? 11'(WR_WAIT) : 11'(RD_WAIT);
  // Accept once the wait count has run out; a zero count accepts at once
  assign accept = req && (active_q ? (wait_q == '0)
                                   : (first_wait == '0));
  assign link.waitrequest = req && !accept;

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      wait_q   <= '0;
      active_q <= 1'b0;
    end else if (!req || accept) begin
      // Clear while no request and on acceptance, ready for the next transfer
      active_q <= 1'b0;
      wait_q   <= '0;
    end else if (!active_q) begin
      // First cycle is already one wait state
      active_q <= 1'b1;
      wait_q   <= first_wait - 11'h001;
    end else if (wait_q != '0) begin
      wait_q <= wait_q - 11'h001;
    end
  end

  // Next beat address: increment, or wrap inside the burst window
  function automatic logic [`MMT_ADDR_W-1:0] next_addr(input logic [`MMT_ADDR_W-1:0] a,
                                                       input logic [`MMT_ADDR_W-1:0] base,
                                                       input logic [`MMT_BCNT_W-1:0] n);
    logic [`MMT_ADDR_W-1:0] span;
    logic [`MMT_ADDR_W-1:0] inc;
    span = {{(`MMT_ADDR_W-`MMT_BCNT_W-2){1'b0}}, n, 2'b00};
    inc  = a + 16'h0004;
    if (WRAPPING_BURST_ENABLE && span != '0 && (span & (span - 16'h0001)) == '0)
      return (base & ~(span - 16'h0001)) | (inc & (span - 16'h0001));
    return inc;
  endfunction

  logic [`MMT_BCNT_W-1:0] burst_len_q;
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      beats_q      <= '0;
      burst_len_q  <= '0;
      burst_addr_q <= '0;
      base_addr_q  <= '0;
    end else if (accept) begin
      if (beats_q == '0) begin
        if (link.burstcount > `MMT_BCNT_W'(1)) begin
          beats_q      <= link.burstcount - `MMT_BCNT_W'(1);
          burst_len_q  <= link.burstcount;
          base_addr_q  <= link.address;
          burst_addr_q <= next_addr(link.address, link.address, link.burstcount);
        end
      end else begin
        beats_q      <= beats_q - `MMT_BCNT_W'(1);
        burst_addr_q <= next_addr(burst_addr_q, base_addr_q, burst_len_q);
      end
    end
  end

  // ==========================================================
  // Storage and write path
  logic [`MMT_DATA_W-1:0] mem_q [MEM_WORDS];
  logic [IDX_W-1:0]       idx;
  assign idx = cur_addr[IDX_W+1:2];

  always_ff @(posedge clk_i) begin
    if (accept && link.write) begin
      for (int b = 0; b < `MMT_BE_W; b++) begin
        if (link.byteenable[b])
          mem_q[idx][b*8 +: 8] <= link.writedata[b*8 +: 8];
      end
    end
  end

  // ==========================================================
  // Read return pipeline
  logic [PIPE_N-1:0]      vld_q;
  logic [`MMT_DATA_W-1:0] dat_q [PIPE_N];
  logic [`MMT_DATA_W-1:0] rd_word;
  assign rd_word = mem_q[idx];

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      vld_q <= '0;
      for (int i = 0; i < PIPE_N; i++)
        dat_q[i] <= '0;
    end else begin
      vld_q[0] <= accept && link.read;
      dat_q[0] <= rd_word;
      for (int i = 1; i < PIPE_N; i++) begin
        vld_q[i] <= vld_q[i-1];
        dat_q[i] <= dat_q[i-1];
      end
    end
  end

  // Zero latency answers in the accepting cycle
  assign link.readdata = (RD_LAT == 0) ? rd_word : dat_q[PIPE_N-1];
  assign link.readdatavalid = USE_READDATAVALID ? vld_q[PIPE_N-1] : 1'b0;

  // ==========================================================
  // Bridge: same bytes forwarded
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      bridge_req_o   <= 1'b0;
      bridge_write_o <= 1'b0;
      bridge_addr_o  <= '0;
      bridge_be_o    <= '0;
      bridge_wdata_o <= '0;
    end else begin
      bridge_req_o <= accept;
      if (accept) begin
        bridge_write_o <= link.write;
        bridge_addr_o  <= cur_addr;
        bridge_be_o    <= link.byteenable;
        bridge_wdata_o <= link.writedata;
      end
    end
  end
endmodule

// File: test/mmt_link_asserts.sv
// Concurrent checks on the link between master end and slave end
`timescale 1ns/1ns
`include "mmt_defs.svh"
module mmt_link_asserts #(
  parameter int WRITE_WAIT_COUNT   = 0,
  parameter int READ_WAIT_COUNT    = 1,
  parameter int BURST_LENGTH_LIMIT = 1,
  parameter bit USE_READDATAVALID  = 1'b0
) (
  // Clock and reset
  input wire logic                   clk_i,
  input wire logic                   reset_i,
  // Link
  input wire logic                   chipselect,
  input wire logic                   read,
  input wire logic                   write,
  input wire logic [`MMT_ADDR_W-1:0] address,
  input wire logic [`MMT_BE_W-1:0]   byteenable,
  input wire logic [`MMT_DATA_W-1:0] writedata,
  input wire logic [`MMT_BCNT_W-1:0] burstcount,
  input wire logic                   beginbursttransfer,
  input wire logic [`MMT_DATA_W-1:0] readdata,
  input wire logic                   readdatavalid,
  input wire logic                   waitrequest
);
  wire logic  req_w;
  logic [10:0] wait_cnt_q;
  assign req_w = chipselect && (read || write);
  // ========================================
  // Wait cycles seen by the pending request
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      wait_cnt_q <= '0;
    end else if (req_w && waitrequest) begin
      wait_cnt_q <= wait_cnt_q + 11'h001;
    end else begin
      wait_cnt_q <= '0;
    end
  end
  // ========================================
  // Properties
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);
  a_write_wait_len: assert property (req_w && write && !waitrequest |->
    int'(wait_cnt_q) == WRITE_WAIT_COUNT) else $error("write accepted after wrong wait");
  a_read_wait_len: assert property (req_w && read && !waitrequest |->
    int'(wait_cnt_q) == READ_WAIT_COUNT) else $error("read answered after wrong wait");
  a_stall_holds_req: assert property (req_w && waitrequest |=> $stable(address) &&
    $stable(byteenable) && $stable(writedata) && $stable(read) && $stable(write))
    else $error("request changed while stalled");
  a_rdv_unused: assert property (!USE_READDATAVALID |-> !readdatavalid)
    else $error("valid pulse in fixed latency mode");
  a_setup_before_strobe: assert property ($rose(read || write) |-> $past(chipselect))
    else $error("strobe without setup");
  a_strobe_has_select: assert property ((read || write) |-> chipselect)
    else $error("strobe without chipselect");
  a_hold_after_write: assert property ($fell(write) |-> chipselect &&
    $stable(address) && $stable(writedata)) else $error("write hold violated");
  a_burst_len_cap: assert property (req_w |-> int'(burstcount) <= BURST_LENGTH_LIMIT)
    else $error("burst over limit");
  a_burst_aligned: assert property (beginbursttransfer |-> address[1:0] == 2'b00)
    else $error("burst start unaligned");
endmodule

// File: test/tb.sv
// Self-checking bench: APB-driven master end joined to slave end
`timescale 1ns/1ns
`include "mmt_defs.svh"
module tb;
  logic        clk_i   = 1'b0;
  logic        reset_i = 1'b1;
  logic        psel_i  = 1'b0;
  logic        penable_i = 1'b0;
  logic        pwrite_i  = 1'b0;
  logic [11:0] paddr_i   = 12'h000;
  logic [31:0] pwdata_i  = 32'h0000_0000;
  logic [31:0] prdata_o;
  logic        pready_o;
  logic        pslverr_o;
  logic        bridge_req_o;
  logic        bridge_write_o;
  logic [15:0] bridge_addr_o;
  logic [3:0]  bridge_be_o;
  logic [31:0] bridge_wdata_o;
  logic [15:0] br_addr;
  logic [4:0]  br_ctl;
  logic [31:0] br_wdata;
  int          fails = 0;
  int          samples_checked = 0;
  localparam int SETUP_INTERVAL = 1;
  localparam int HOLD_INTERVAL  = 1;
  localparam int WR_WAIT_CYC    = 2;
  localparam int RD_WAIT_CYC    = 1;

  always #5 clk_i = ~clk_i;

  mmt_link_if mmt_link_if_inst ();
  mmt_master #(.STROBE_SETUP_INTERVAL(SETUP_INTERVAL), .STROBE_HOLD_INTERVAL(HOLD_INTERVAL))
  mmt_master_inst (
    .clk_i(clk_i), .reset_i(reset_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .link(mmt_link_if_inst));
  mmt_slave #(.WRITE_WAIT_COUNT(WR_WAIT_CYC), .READ_WAIT_COUNT(RD_WAIT_CYC)) mmt_slave_inst (
    .clk_i(clk_i), .reset_i(reset_i), .link(mmt_link_if_inst), .bridge_req_o(bridge_req_o),
    .bridge_write_o(bridge_write_o), .bridge_addr_o(bridge_addr_o),
    .bridge_be_o(bridge_be_o), .bridge_wdata_o(bridge_wdata_o));
  mmt_link_asserts #(.WRITE_WAIT_COUNT(WR_WAIT_CYC), .READ_WAIT_COUNT(RD_WAIT_CYC))
  mmt_link_asserts_inst (
    .clk_i(clk_i), .reset_i(reset_i), .chipselect(mmt_link_if_inst.chipselect),
    .read(mmt_link_if_inst.read), .write(mmt_link_if_inst.write),
    .address(mmt_link_if_inst.address), .byteenable(mmt_link_if_inst.byteenable),
    .writedata(mmt_link_if_inst.writedata), .burstcount(mmt_link_if_inst.burstcount),
    .beginbursttransfer(mmt_link_if_inst.beginbursttransfer),
    .readdata(mmt_link_if_inst.readdata), .readdatavalid(mmt_link_if_inst.readdatavalid),
    .waitrequest(mmt_link_if_inst.waitrequest));

  // Capture of the beat handed to the paired master side
  always @(posedge clk_i) begin
    if (bridge_req_o === 1'b1) begin
      br_addr  <= bridge_addr_o;
      br_ctl   <= {bridge_write_o, bridge_be_o};
      br_wdata <= bridge_wdata_o;
    end
  end

  function automatic logic [31:0] merge(input logic [31:0] old_w, input logic [31:0] new_w,
                                        input logic [3:0] be);
    for (int b = 0; b < 4; b++) begin
      if (be[b]) old_w[8*b+:8] = new_w[8*b+:8];
    end
    return old_w;
  endfunction

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    n = 0;
    @(posedge clk_i);
    psel_i    <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i  <= w;
    paddr_i   <= a;
    pwdata_i  <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    do begin
      @(posedge clk_i);
      n++;
    end while (pready_o !== 1'b1 && n < 40);
    if (n >= 40) fails++;
    r = prdata_o;
    e = pslverr_o;
    psel_i    <= 1'b0;
    penable_i <= 1'b0;
  endtask

  task automatic xfer(input logic w, input int idx, input logic [31:0] d, input logic [3:0] be,
                      output logic [31:0] r);
    logic [31:0] s;
    logic        e;
    int          n;
    n = 0;
    apb(1'b1, `MMT_REG_ADDR, 32'(idx) << 2, s, e);
    apb(1'b1, `MMT_REG_WDATA, d, s, e);
    apb(1'b1, `MMT_REG_CTRL, {17'h0_0000, 7'h01, be, 2'b00, w, 1'b1}, s, e);
    do begin
      apb(1'b0, `MMT_REG_STATUS, 32'h0000_0000, s, e);
      n++;
    end while (s[`MMT_STAT_BUSY] !== 1'b0 && n < 50);
    if (n >= 50) fails++;
    if (!w) apb(1'b0, `MMT_REG_RDATA, 32'h0000_0000, r, e);
    @(posedge clk_i);
    check(32'(br_addr), 32'(idx) << 2);
    check(32'(br_ctl), 32'({w, be}));
    if (w) check(br_wdata, d);
  endtask

  initial begin
    logic [31:0] r;
    logic [31:0] d0;
    logic [31:0] d1;
    logic [3:0]  be;
    logic        e;
    int          idx;
    repeat (3) @(posedge clk_i);
    reset_i <= 1'b0;
    void'($urandom(9));
    for (int i = 0; i < 12; i++) begin
      idx = (i == 0) ? 0 : (i == 1) ? 63 : int'($urandom_range(63));
      be  = (i == 0) ? 4'h1 : (i == 1) ? 4'h8 : 4'($urandom_range(15, 1));
      d0  = $urandom;
      d1  = $urandom;
      xfer(1'b1, idx, d0, 4'hF, r);
      xfer(1'b1, idx, d1, be, r);
      xfer(1'b0, idx, 32'h0000_0000, 4'hF, r);
      check(r, merge(d0, d1, be));
    end
    apb(1'b1, 12'hFFC, 32'h0000_0000, r, e);
    check(32'(e), 32'h0000_0001);
    print_verdict();
  end

  initial begin
    #300000;
    fails++;
    print_verdict();
  end
endmodule
